//--- design/pdcs_map.vh
// register offsets, field positions, reset values and timing values in ns of the device control/status bank
`ifndef PDCS_MAP_VH
`define PDCS_MAP_VH
`define PDCS_DEV_CONTROL_OFFSET 8'h78
`define PDCS_DEV_STATUS_OFFSET  8'h7a
`define PDCS_DEV_CONTROL_RESET  16'h2000
`define PDCS_DEV_STATUS_RESET   16'h0000
`define PDCS_CTL_RETRY_BIT      15
`define PDCS_CTL_MAX_READ_REQUEST_SIZE_HI        14
`define PDCS_CTL_MAX_READ_REQUEST_SIZE_LO        12
`define PDCS_CTL_NOSNOOP_BIT    11
`define PDCS_CTL_AUXPM_BIT      10
`define PDCS_CTL_PHANTOM_BIT    9
`define PDCS_CTL_EXTTAG_BIT     8
`define PDCS_CTL_MPS_HI         7
`define PDCS_CTL_MPS_LO         5
`define PDCS_CTL_RELAX_BIT      4
`define PDCS_CTL_UNSUPPORTED_REQUEST_REPORT_ENABLE_BIT       3
`define PDCS_CTL_FATAL_ERROR_REPORT_ENABLE_BIT       2
`define PDCS_CTL_NONFATAL_ERROR_REPORT_ENABLE_BIT      1
`define PDCS_CTL_CORRECTABLE_ERROR_REPORT_ENABLE_BIT       0
`define PDCS_STS_TRANSACTION_OUTSTANDING_BIT       5
`define PDCS_STS_AUX_BIT        4
`define PDCS_STS_URD_BIT        3
`define PDCS_STS_FED_BIT        2
`define PDCS_STS_NONFATAL_ERROR_SEEN_BIT       1
`define PDCS_STS_CED_BIT        0
`define PDCS_SIZE_128           3'h0
`define PDCS_SIZE_512           3'h2
`define PDCS_SIZE_4096          3'h5
`define PDCS_CFG_TIMEOUT_NS     1000
`define PDCS_CLK_PERIOD_NS      4
`define PDCS_OUTSTANDING_BITS   6
`endif

//--- design/pdcs_sync2.v
// two flip-flop synchroniser for a single pin level
`timescale 1ns/1ns
module pdcs_sync2 (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg stage1;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

//--- design/pdcs_device_regs.v
// device control and device status registers with their side effects on the bridge core
//
// Function
// [R1] retry enabled: time-out answers retry-status completion
// [R2] retry disabled: never retry-status; resets zero
// [R3] read size field, codes 000-101, reset 512
// [R4] read requests limited to read size
// [R5] no-snoop enable reads zero, ignores writes
// [R6] aux power enable writable, no effect
// [R7] phantom, extended tag, relaxed ordering read zero
// [R8] payload size field limits writes, completions; 128
// [R9] unsupported request reported nonfatal when enabled
// [R10] fatal messages only when fatal enable set
// [R11] nonfatal messages only when nonfatal enable set; unsupported requests send one under their own enable alone
// [R12] correctable messages only when enable set
// [R13] pending bit shows outstanding non-posted requests
// [R14] aux power bit follows aux power presence
// [R15] unsupported request seen set regardless enable
// [R16] fatal error seen set on fatal error
// [R17] nonfatal error seen set on nonfatal
// [R18] correctable error seen set on correctable
// [R19] status bits 15:6 read zero
// [R20] write one clears seen bits; set wins
`timescale 1ns/1ns
`include "pdcs_map.vh"
module pdcs_device_regs (
  input  wire        clk,
  input  wire        rst,
  // configuration access from the upstream link
  input  wire        cfgWrite,
  input  wire        cfgRead,
  input  wire [7:0]  cfgAddr,
  input  wire [1:0]  cfgByteEnable,
  input  wire [15:0] cfgWriteData,
  output reg  [15:0] cfgReadData,
  output reg         cfgReadValid,
  // downstream configuration cycle tracking
  input  wire        fwdCfgStart,
  input  wire        fwdCfgDone,
  output reg         cfgRetryCompletion,
  // request sizing
  input  wire [12:0] readWantBytes,
  output reg  [12:0] readGrantBytes,
  output reg  [12:0] maxReadRequestBytes,
  output reg  [12:0] maxPayloadBytes,
  // non-posted tracking
  input  wire        nonPostedIssue,
  input  wire        completionReceived,
  // error events from the core
  input  wire        unsupportedRequest,
  input  wire        fatalError,
  input  wire        nonfatalError,
  input  wire        correctableError,
  output reg         sendErrFatal,
  output reg         sendErrNonfatal,
  output reg         sendErrCor,
  // pin
  input  wire        auxPowerPin
);
  // ********************************
  // constants and helpers
  // ********************************
  localparam integer TIMEOUT_CYCLES = `PDCS_CFG_TIMEOUT_NS / `PDCS_CLK_PERIOD_NS;
  // fixed wait; a slow secondary bus would need a longer count here
  localparam [9:0]   TIMEOUT_LAST   = TIMEOUT_CYCLES[9:0] - 10'h001;
  localparam [1:0]   FWD_IDLE       = 2'h0;
  localparam [1:0]   FWD_WAIT       = 2'h1;

  // reserved codes clamp to the largest legal size
  function [12:0] sizeBytes;
    input [2:0] code;
    begin
      if (code > `PDCS_SIZE_4096)
        sizeBytes = 13'h1000;
      else
        sizeBytes = 13'h0080 << code;
    end
  endfunction

  // write-one-to-clear decode shared by the four seen bits, all in lane 0
  function clearsBit;
    input       hit;
    input [1:0] lanes;
    input       dataBit;
    begin
      clearsBit = hit && lanes[0] && dataBit;
    end
  endfunction

  // ********************************
  // registers
  // ********************************
  reg        retryEnable;
  reg [2:0]  readSizeCode;
  reg        auxPmEnable;
  reg [2:0]  payloadCode;
  reg        urReportEnable;
  reg        fatalReportEnable;
  reg        nonfatalReportEnable;
  reg        corReportEnable;
  reg        urSeen;
  reg        fatalSeen;
  reg        nonfatalSeen;
  reg        corSeen;
  reg [5:0]  outstanding;
  reg [1:0]  fwdState;
  reg [9:0]  fwdCount;
  wire       auxPowerSync;
  wire       ctlHit;
  wire       stsHit;
  wire       wrCtl;
  wire       wrSts;
  wire [15:0] controlValue;
  wire [15:0] statusValue;
  wire [1:0] next_outstandingDelta;
  wire        urClear;
  wire        fatalClear;
  wire        nonfatalClear;
  wire        corClear;
  wire [12:0] readLimitBytes;
  wire [12:0] payloadLimitBytes;
  reg  [15:0] next_cfgReadData;

  // the pin is asynchronous to the bank clock
  pdcs_sync2 auxSync (
    .clk  (clk),
    .rst  (rst),
    .din  (auxPowerPin),
    .dout (auxPowerSync)
  );

  assign ctlHit = cfgAddr == `PDCS_DEV_CONTROL_OFFSET;
  assign stsHit = cfgAddr == `PDCS_DEV_STATUS_OFFSET;
  assign wrCtl  = cfgWrite && ctlHit;
  assign wrSts  = cfgWrite && stsHit;

  assign urClear           = clearsBit(wrSts, cfgByteEnable, cfgWriteData[`PDCS_STS_URD_BIT]); // [R20]
  assign fatalClear        = clearsBit(wrSts, cfgByteEnable, cfgWriteData[`PDCS_STS_FED_BIT]); // [R20]
  assign nonfatalClear     = clearsBit(wrSts, cfgByteEnable, cfgWriteData[`PDCS_STS_NONFATAL_ERROR_SEEN_BIT]); // [R20]
  assign corClear          = clearsBit(wrSts, cfgByteEnable, cfgWriteData[`PDCS_STS_CED_BIT]); // [R20]
  assign readLimitBytes    = sizeBytes(readSizeCode); // [R4]
  assign payloadLimitBytes = sizeBytes(payloadCode); // [R8]

  // fixed-zero fields are never stored
  assign controlValue = {retryEnable, readSizeCode, 1'b0, auxPmEnable, 1'b0, 1'b0,
                         payloadCode, 1'b0, urReportEnable, fatalReportEnable,
                         nonfatalReportEnable, corReportEnable}; // [R5] [R7]
  assign statusValue  = {10'h000, (outstanding != 6'h00), auxPowerSync,
                         urSeen, fatalSeen, nonfatalSeen, corSeen}; // [R13] [R14] [R19]

  // ********************************
  // device control writes
  // ********************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      retryEnable          <= 1'b0; // [R2]
      readSizeCode         <= `PDCS_SIZE_512; // [R3]
      auxPmEnable          <= 1'b0; // [R6]
      payloadCode          <= `PDCS_SIZE_128; // [R8]
      urReportEnable       <= 1'b0;
      fatalReportEnable    <= 1'b0;
      nonfatalReportEnable <= 1'b0;
      corReportEnable      <= 1'b0;
    end else if (wrCtl) begin
      if (cfgByteEnable[1]) begin
        retryEnable  <= cfgWriteData[`PDCS_CTL_RETRY_BIT];
        readSizeCode <= cfgWriteData[`PDCS_CTL_MAX_READ_REQUEST_SIZE_HI:`PDCS_CTL_MAX_READ_REQUEST_SIZE_LO]; // [R3]
        auxPmEnable  <= cfgWriteData[`PDCS_CTL_AUXPM_BIT]; // [R6]
      end
      if (cfgByteEnable[0]) begin
        payloadCode          <= cfgWriteData[`PDCS_CTL_MPS_HI:`PDCS_CTL_MPS_LO]; // [R8]
        urReportEnable       <= cfgWriteData[`PDCS_CTL_UNSUPPORTED_REQUEST_REPORT_ENABLE_BIT];
        fatalReportEnable    <= cfgWriteData[`PDCS_CTL_FATAL_ERROR_REPORT_ENABLE_BIT];
        nonfatalReportEnable <= cfgWriteData[`PDCS_CTL_NONFATAL_ERROR_REPORT_ENABLE_BIT];
        corReportEnable      <= cfgWriteData[`PDCS_CTL_CORRECTABLE_ERROR_REPORT_ENABLE_BIT];
      end
    end
  end

  // ********************************
  // device status sticky bits
  // ********************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      urSeen       <= 1'b0;
      fatalSeen    <= 1'b0;
      nonfatalSeen <= 1'b0;
      corSeen      <= 1'b0;
    end else begin
      // the set is tested first so an event in the clear cycle is never lost
      if (unsupportedRequest)
        urSeen <= 1'b1; // [R15]
      else if (urClear)
        urSeen <= 1'b0; // [R20]
      if (fatalError)
        fatalSeen <= 1'b1; // [R16]
      else if (fatalClear)
        fatalSeen <= 1'b0; // [R20]
      if (nonfatalError)
        nonfatalSeen <= 1'b1; // [R17]
      else if (nonfatalClear)
        nonfatalSeen <= 1'b0; // [R20]
      if (correctableError)
        corSeen <= 1'b1; // [R18]
      else if (corClear)
        corSeen <= 1'b0; // [R20]
    end
  end

  // ********************************
  // outstanding non-posted requests
  // ********************************
  // saturates rather than wraps, since a wrap would drop the pending bit
  assign next_outstandingDelta = {nonPostedIssue, completionReceived};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      outstanding <= 6'h00;
    end else begin
      case (next_outstandingDelta)
        2'b10: if (outstanding != 6'h3f) outstanding <= outstanding + 6'h01; // [R13]
        2'b01: if (outstanding != 6'h00) outstanding <= outstanding - 6'h01; // [R13]
        default: outstanding <= outstanding;
      endcase
    end
  end

  // ********************************
  // forwarded configuration time-out
  // ********************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fwdState           <= FWD_IDLE;
      fwdCount           <= 10'h000;
      cfgRetryCompletion <= 1'b0;
    end else begin
      cfgRetryCompletion <= 1'b0;
      case (fwdState)
        FWD_IDLE: begin
          fwdCount <= 10'h000;
          if (fwdCfgStart)
            fwdState <= FWD_WAIT;
        end
        FWD_WAIT: begin
          if (fwdCfgDone) begin
            fwdState <= FWD_IDLE;
          end else if (fwdCount == TIMEOUT_LAST) begin
            // disabled: keep waiting for the real completion
            if (retryEnable) begin
              cfgRetryCompletion <= 1'b1; // [R1] [R2]
              fwdState           <= FWD_IDLE;
            end
          end else begin
            fwdCount <= fwdCount + 10'h001;
          end
        end
        default: fwdState <= FWD_IDLE;
      endcase
    end
  end

  // ********************************
  // sizes and error messages
  // ********************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      maxReadRequestBytes <= 13'h0000;
      maxPayloadBytes     <= 13'h0000;
      readGrantBytes      <= 13'h0000;
      sendErrFatal        <= 1'b0;
      sendErrNonfatal     <= 1'b0;
      sendErrCor          <= 1'b0;
    end else begin
      // the core sees new sizes one clock after the control write
      maxReadRequestBytes <= readLimitBytes; // [R4]
      maxPayloadBytes     <= payloadLimitBytes; // [R8]
      readGrantBytes      <= (readWantBytes > readLimitBytes) ? readLimitBytes : readWantBytes; // [R4]
      sendErrFatal        <= fatalError && fatalReportEnable; // [R10]
      // unsupported requests share the nonfatal message under their own enable
      sendErrNonfatal     <= (nonfatalError && nonfatalReportEnable) ||
                             (unsupportedRequest && urReportEnable); // [R9] [R11]
      sendErrCor          <= correctableError && corReportEnable; // [R12]
    end
  end

  // ********************************
  // configuration reads
  // ********************************
  // unmapped offsets read zero so software probing past the bank sees nothing
  always @* begin
    case (cfgAddr)
      `PDCS_DEV_CONTROL_OFFSET: next_cfgReadData = controlValue; // [R5] [R7]
      `PDCS_DEV_STATUS_OFFSET:  next_cfgReadData = statusValue; // [R19]
      default:                  next_cfgReadData = 16'h0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgReadData  <= 16'h0000;
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadValid <= cfgRead;
      if (cfgRead)
        cfgReadData <= next_cfgReadData;
    end
  end
endmodule

//--- tb/pdcs_root_model.sv
// root complex model: counts error messages and retry completions sent upstream
`timescale 1ns/1ns
module pdcs_root_model (
  input  wire logic       clk,
  input  wire logic       sendErrFatal,
  input  wire logic       sendErrNonfatal,
  input  wire logic       sendErrCor,
  input  wire logic       cfgRetryCompletion,
  output logic      [7:0] nFat,
  output logic      [7:0] nNon,
  output logic      [7:0] nCor,
  output logic      [7:0] nRetry
);
  // ****************************************
  // message sink
  // ****************************************
  // every one-cycle pulse is one message on the link, so a count is all software sees
  initial {nFat, nNon, nCor, nRetry} = 32'h0;
  always @(posedge clk) begin
    nFat   <= nFat + sendErrFatal;
    nNon   <= nNon + sendErrNonfatal;
    nCor   <= nCor + sendErrCor;
    nRetry <= nRetry + cfgRetryCompletion;
  end
endmodule

//--- tb/pdcs_device_regs_sva.sv
// assertions on the ports of the device control and status bank
`timescale 1ns/1ns
module pdcs_device_regs_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cfgRead,
  input wire logic [7:0]  cfgAddr,
  input wire logic [15:0] cfgReadData,
  input wire logic        cfgReadValid,
  input wire logic        fwdCfgStart,
  input wire logic        cfgRetryCompletion,
  input wire logic [12:0] readGrantBytes,
  input wire logic [12:0] maxReadRequestBytes,
  input wire logic [12:0] maxPayloadBytes,
  input wire logic        unsupportedRequest,
  input wire logic        fatalError,
  input wire logic        nonfatalError,
  input wire logic        correctableError,
  input wire logic        sendErrFatal,
  input wire logic        sendErrNonfatal,
  input wire logic        sendErrCor
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  retry_delay_a: assert property ($rose(cfgRetryCompletion) |-> $past(fwdCfgStart, 250) ||
    $past(fwdCfgStart, 251) || $past(fwdCfgStart, 252)) else $error("retry completion off its time-out");
  fatal_cause_a: assert property (sendErrFatal |-> $past(fatalError)) else $error("fatal message without event");
  nonfat_cause_a: assert property (sendErrNonfatal |-> $past(nonfatalError || unsupportedRequest))
    else $error("nonfatal message without event");
  cor_cause_a: assert property (sendErrCor |-> $past(correctableError)) else $error("correctable message without event");
  read_answer_a: assert property (cfgRead |=> cfgReadValid) else $error("read not answered");
  ctl_fixed_a: assert property (cfgRead && cfgAddr == 8'h78 |=> (cfgReadData & 16'h0b10) == 16'h0)
    else $error("fixed control bits read nonzero");
  sts_rsvd_a: assert property (cfgRead && cfgAddr == 8'h7a |=> cfgReadData[15:6] == 10'h0)
    else $error("reserved status bits nonzero");
  grant_limit_a: assert property ($stable(maxReadRequestBytes) |-> readGrantBytes <= maxReadRequestBytes)
    else $error("read request above limit");
  payload_code_a: assert property (!$past(rst) |-> $onehot(maxPayloadBytes) && maxPayloadBytes >= 13'd128)
    else $error("payload size not a legal size");
  c_retry: cover property ($rose(cfgRetryCompletion));
  c_nonfat: cover property (sendErrNonfatal);
  c_clip: cover property (readGrantBytes == maxReadRequestBytes);
endmodule
bind pdcs_device_regs pdcs_device_regs_sva pdcs_device_regs_sva_i (.clk, .rst, .cfgRead, .cfgAddr, .cfgReadData,
  .cfgReadValid, .fwdCfgStart, .cfgRetryCompletion, .readGrantBytes, .maxReadRequestBytes, .maxPayloadBytes,
  .unsupportedRequest, .fatalError, .nonfatalError, .correctableError, .sendErrFatal, .sendErrNonfatal, .sendErrCor);

//--- tb/pcie_device_control_status_tb.sv
// self-checking bench for the device control and status bank
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module pcie_device_control_status_tb;
  logic        clk = 0, rst = 1, cfgWrite = 0, cfgRead = 0, auxPowerPin = 0;
  logic [7:0]  cfgAddr = 0, pv = 0, nFat, nNon, nCor, nRetry;
  logic [1:0]  cfgByteEnable = 2'h3;
  logic [15:0] cfgWriteData = 0, cfgReadData, e;
  logic [12:0] readWantBytes = 0, readGrantBytes, maxReadRequestBytes, maxPayloadBytes, g;
  logic        cfgReadValid, cfgRetryCompletion, sendErrFatal, sendErrNonfatal, sendErrCor;
  logic [31:0] seed = 32'hde20, d;
  logic [15:0] expQ[$];
  int          num_errors = 0, n_tests = 0;
  // ****************************************
  // device and root complex
  // ****************************************
  always #2 clk = ~clk;
  pdcs_device_regs pdcs_device_regs_i (.clk, .rst, .cfgWrite, .cfgRead, .cfgAddr, .cfgByteEnable, .cfgWriteData,
    .cfgReadData, .cfgReadValid, .fwdCfgStart(pv[6]), .fwdCfgDone(pv[7]), .cfgRetryCompletion, .readWantBytes,
    .readGrantBytes, .maxReadRequestBytes, .maxPayloadBytes, .nonPostedIssue(pv[4]), .completionReceived(pv[5]),
    .unsupportedRequest(pv[3]), .fatalError(pv[2]), .nonfatalError(pv[1]), .correctableError(pv[0]),
    .sendErrFatal, .sendErrNonfatal, .sendErrCor, .auxPowerPin);
  pdcs_root_model pdcs_root_model_i (.clk, .sendErrFatal, .sendErrNonfatal, .sendErrCor, .cfgRetryCompletion,
    .nFat, .nNon, .nCor, .nRetry);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reserved codes behave as the largest size
  function automatic logic [12:0] sz(input logic [2:0] c);
    return (c > 3'h5) ? 13'd4096 : (13'd128 << c);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk) {cfgWrite, cfgAddr, cfgWriteData} = {1'b1, a, v};
    @(negedge clk) cfgWrite = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk) {cfgRead, cfgAddr} = {1'b1, a};
    expQ.push_back(v);
    @(negedge clk) cfgRead = 0;
  endtask
  task automatic pls(input logic [7:0] m);
    @(negedge clk) pv = m;
    @(negedge clk) pv = 0;
  endtask
  task automatic tend(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // read valid is only high for one cycle, so look mid-cycle
  always @(negedge clk) if (cfgReadValid === 1'b1) begin
    e = expQ.pop_front();
    `CHK(cfgReadData, e)
  end
  initial begin
    #40000;
    num_errors++;
    final_report();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    rd(8'h78, 16'h2000);
    rd(8'h7a, 16'h0000);
    wr(8'h78, 16'hffff);
    rd(8'h78, 16'hf4ef);
    tend("reset");
    for (int i = 0; i < 4; i++) begin
      d = xs();
      wr(8'h78, d[15:0]);
      rd(8'h78, d[15:0] & 16'hf4ef);
      readWantBytes = d[28:16];
      repeat (2) @(negedge clk);
      g = sz(d[14:12]);
      `CHK(maxReadRequestBytes, g)
      `CHK(maxPayloadBytes, sz(d[7:5]))
      `CHK(readGrantBytes, (readWantBytes < g) ? readWantBytes : g)
    end
    tend("sizes");
    for (int k = 0; k < 2; k++) begin
      wr(8'h78, k ? 16'h0 : 16'h000f);
      for (int j = 0; j < 4; j++) pls(8'h1 << j);
    end
    rd(8'h7a, 16'h000f);
    `CHK({nFat, nNon, nCor}, {8'd1, 8'd2, 8'd1})
    wr(8'h7a, 16'h0001);
    rd(8'h7a, 16'h000e);
    cfgByteEnable = 2'h2;
    wr(8'h7a, 16'hffff);
    rd(8'h7a, 16'h000e);
    wr(8'h78, 16'hffff);
    rd(8'h78, 16'hf400);
    cfgByteEnable = 2'h3;
    wr(8'h7a, 16'hffff);
    rd(8'h7a, 16'h0000);
    fork
      wr(8'h7a, 16'h0001);
      pls(8'h01);
    join
    rd(8'h7a, 16'h0001);
    wr(8'h7a, 16'h0001);
    tend("errors");
    pls(8'h10);
    rd(8'h7a, 16'h0020);
    pls(8'h20);
    rd(8'h7a, 16'h0000);
    auxPowerPin = 1;
    repeat (4) @(negedge clk);
    rd(8'h7a, 16'h0010);
    tend("status");
    wr(8'h78, 16'h8000);
    pls(8'h40);
    repeat (240) @(negedge clk);
    `CHK(nRetry, 8'd0)
    repeat (20) @(negedge clk);
    `CHK(nRetry, 8'd1)
    pls(8'h80);
    wr(8'h78, 16'h0);
    pls(8'h40);
    repeat (260) @(negedge clk);
    `CHK(nRetry, 8'd1)
    pls(8'h80);
    rd(8'h40, 16'h0000);
    tend("retry");
    repeat (3) @(negedge clk);
    final_report();
  end
endmodule
